// ---- core/adc_window_irq_status_defines.svh ----
`ifndef ADC_WINDOW_IRQ_STATUS_DEFINES_SVH
`define ADC_WINDOW_IRQ_STATUS_DEFINES_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
`define IDX_TIMEBASE_REF 6'h02
`define IDX_WINDOW_CTRL 6'h03
`define IDX_IRQ_ENABLE 6'h04
`define IDX_IRQ_FLAGS 6'h05
`define IDX_STATUS 6'h06
`define IDX_ACC_COUNT 6'h09
`define IDX_RESULT 6'h10
`define IDX_SAMPLE 6'h14
`define IDX_WIN_LOW 6'h1c
`define IDX_WIN_HIGH 6'h1e

// ==========================================================================
// Field positions.
`define TIMEBASE_MSB 7
`define TIMEBASE_LSB 3
`define REFERENCE_SELECT_MSB 2
`define REFERENCE_SELECT_LSB 0
`define REFERENCE_SELECT_INTERNAL_BIT 2
`define WINDOW_SOURCE_SELECT_BIT 3
`define WINDOW_COMPARE_MODE_MSB 2
`define WINDOW_COMPARE_MODE_LSB 0
`define ACC_COUNT_MSB 3
`define ACC_COUNT_LSB 0
`define STATUS_BUSY_BIT 0

// ==========================================================================
// Codes and reset values.
`define WINDOW_COMPARE_MODE_NONE 3'h0
`define WINDOW_COMPARE_MODE_BELOW 3'h1
`define WINDOW_COMPARE_MODE_ABOVE 3'h2
`define WINDOW_COMPARE_MODE_INSIDE 3'h3
`define WINDOW_COMPARE_MODE_OUTSIDE 3'h4
`define ACC_COUNT_MAX 4'ha
`define REG8_RESET 8'h00
`define REG16_RESET 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ==========================================================================
// Times in microseconds, counted in timebase ticks.
`define REF_INIT_TIME_US 7'h3c
`define GUARD_TIME_US 7'h01

`endif

// ---- core/adc_window_irq_status_pkg.sv ----
package adc_window_irq_status_pkg;

  // ==========================================================================
  // Interrupt enable and flag layout, bit 5 down to bit 0.
  typedef struct packed {
    logic trigger_overrun;
    logic sample_overwrite;
    logic result_overwrite;
    logic window_match;
    logic sample_ready;
    logic result_ready;
  } irq_bits_t;

  // ==========================================================================
  // Sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SETTLE,
    SEQ_CONVERT
  } seq_state_t;

endpackage : adc_window_irq_status_pkg

// ---- core/adc_window_irq_status.sv ----
`timescale 1ns/1ps
`include "adc_window_irq_status_defines.svh"
module adc_window_irq_status
  import adc_window_irq_status_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter core.
  input wire logic start_trigger,
  input wire logic sample_valid,
  input wire logic [15:0] sample_data,
  output logic conv_start,
  output logic [2:0] reference_select,
  output logic converter_busy,
  output logic irq
);

  // ==========================================================================
  // Helpers.
  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = 6'(addr[ADDR_W-1:2]);
  endfunction : reg_index

  function automatic logic is_mapped(input logic [5:0] idx);
    is_mapped = (idx == `IDX_TIMEBASE_REF) || (idx == `IDX_WINDOW_CTRL) || (idx == `IDX_IRQ_ENABLE) ||
                (idx == `IDX_IRQ_FLAGS) || (idx == `IDX_STATUS) || (idx == `IDX_ACC_COUNT) ||
                (idx == `IDX_RESULT) || (idx == `IDX_SAMPLE) || (idx == `IDX_WIN_LOW) ||
                (idx == `IDX_WIN_HIGH);
  endfunction : is_mapped

  function automatic logic win_hit(input logic [2:0] mode, input logic [15:0] v,
                                   input logic [15:0] lo, input logic [15:0] hi);
    case (mode)
      `WINDOW_COMPARE_MODE_BELOW: win_hit = v < lo;
      `WINDOW_COMPARE_MODE_ABOVE: win_hit = v > hi;
      `WINDOW_COMPARE_MODE_INSIDE: win_hit = (v > lo) && (v < hi);
      `WINDOW_COMPARE_MODE_OUTSIDE: win_hit = (v < lo) || (v > hi);
      default: win_hit = 1'b0;
    endcase
  endfunction : win_hit

  // Reserved counts above the largest documented one are treated as the largest.
  function automatic logic [10:0] acc_target(input logic [3:0] n);
    logic [3:0] k;
    k = (n > `ACC_COUNT_MAX) ? `ACC_COUNT_MAX : n;
    acc_target = 11'h001 << k;
  endfunction : acc_target

  // ==========================================================================
  // Registers.
  logic [7:0] timebase_ref_reg;
  logic [7:0] window_ctrl_reg;
  logic [3:0] acc_count_reg;
  logic [15:0] win_low_reg;
  logic [15:0] win_high_reg;
  irq_bits_t irq_enable_reg;
  irq_bits_t irq_flags_reg;
  irq_bits_t irq_flags_next;
  irq_bits_t flag_set;
  irq_bits_t flag_clr;
  logic [31:0] result_reg;
  logic [15:0] sample_reg;
  logic [31:0] acc_sum_reg;
  logic [10:0] acc_cnt_reg;
  logic result_unread_reg;
  logic sample_unread_reg;
  logic [4:0] us_div_reg;
  logic [6:0] settle_us_reg;
  seq_state_t state_reg;

  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  logic [5:0] wr_idx;
  logic rd_go;
  logic [5:0] rd_idx;
  logic us_tick;
  logic settled;
  logic sample_done;
  logic acc_last;
  logic [31:0] acc_new;
  logic [15:0] win_value;
  logic [31:0] rd_value;

  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx = reg_index(awaddr_reg);
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_idx = reg_index(s_axi_araddr);

  // ==========================================================================
  // Write channel: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timebase_ref_reg <= `REG8_RESET;
      window_ctrl_reg <= `REG8_RESET;
      acc_count_reg <= '0;
      irq_enable_reg <= '0;
    end else if (wr_go && wstrb_reg[0]) begin
      case (wr_idx)
        `IDX_TIMEBASE_REF: timebase_ref_reg <= wdata_reg[7:0];
        `IDX_WINDOW_CTRL: window_ctrl_reg <= {4'h0, wdata_reg[`WINDOW_SOURCE_SELECT_BIT:`WINDOW_COMPARE_MODE_LSB]};
        `IDX_ACC_COUNT: acc_count_reg <= wdata_reg[`ACC_COUNT_MSB:`ACC_COUNT_LSB];
        `IDX_IRQ_ENABLE: irq_enable_reg <= irq_bits_t'(wdata_reg[5:0]);
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_low_reg <= `REG16_RESET;
      win_high_reg <= `REG16_RESET;
    end else if (wr_go) begin
      for (int b = 0; b < 2; b++) begin
        if (wstrb_reg[b] && wr_idx == `IDX_WIN_LOW) begin
          win_low_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
        end
        if (wstrb_reg[b] && wr_idx == `IDX_WIN_HIGH) begin
          win_high_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
        end
      end
    end
  end

  assign reference_select = timebase_ref_reg[`REFERENCE_SELECT_MSB:`REFERENCE_SELECT_LSB];

  // ==========================================================================
  // Microsecond timebase and settling delays.
  // The divider restarts on every reference change so the first period is whole.
  logic ref_change;
  assign ref_change = wr_go && wstrb_reg[0] && wr_idx == `IDX_TIMEBASE_REF &&
                      wdata_reg[`REFERENCE_SELECT_MSB:`REFERENCE_SELECT_LSB] != timebase_ref_reg[`REFERENCE_SELECT_MSB:`REFERENCE_SELECT_LSB];
  assign us_tick = us_div_reg == timebase_ref_reg[`TIMEBASE_MSB:`TIMEBASE_LSB];
  assign settled = settle_us_reg == '0;

  always_ff @(posedge aclk) begin
    if (!aresetn || ref_change || us_tick) begin
      us_div_reg <= '0;
    end else begin
      us_div_reg <= us_div_reg + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_us_reg <= '0;
    end else if (ref_change) begin
      settle_us_reg <= wdata_reg[`REFERENCE_SELECT_INTERNAL_BIT] ? `REF_INIT_TIME_US : `GUARD_TIME_US;
    end else if (us_tick && !settled) begin
      settle_us_reg <= settle_us_reg - 7'h01;
    end
  end

  // ==========================================================================
  // Conversion sequencer with accumulation.
  assign sample_done = state_reg == SEQ_CONVERT && sample_valid;
  assign acc_last = acc_cnt_reg + 11'h001 >= acc_target(acc_count_reg);
  assign acc_new = (acc_cnt_reg == '0) ? {16'h0000, sample_data} : acc_sum_reg + {16'h0000, sample_data};

  // A trigger is held through settling; only one waiting start is remembered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SEQ_IDLE;
      conv_start <= 1'b0;
      acc_cnt_reg <= '0;
      acc_sum_reg <= '0;
    end else begin
      conv_start <= 1'b0;
      case (state_reg)
        SEQ_IDLE: begin
          if (start_trigger) begin
            state_reg <= SEQ_SETTLE;
          end
        end
        SEQ_SETTLE: begin
          if (settled && !ref_change) begin
            state_reg <= SEQ_CONVERT;
            conv_start <= 1'b1;
            acc_cnt_reg <= '0;
          end
        end
        SEQ_CONVERT: begin
          if (sample_valid) begin
            acc_sum_reg <= acc_new;
            if (acc_last) begin
              state_reg <= SEQ_IDLE;
            end else begin
              acc_cnt_reg <= acc_cnt_reg + 11'h001;
              conv_start <= 1'b1;
            end
          end
        end
        default: state_reg <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_busy <= 1'b0;
    end else begin
      converter_busy <= (state_reg != SEQ_IDLE) || !settled || start_trigger;
    end
  end

  // ==========================================================================
  // Sample and result registers with unread tracking.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_reg <= `REG16_RESET;
      sample_unread_reg <= 1'b0;
    end else if (sample_done) begin
      sample_reg <= sample_data;
      sample_unread_reg <= 1'b1;
    end else if (rd_go && rd_idx == `IDX_SAMPLE) begin
      sample_unread_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= '0;
      result_unread_reg <= 1'b0;
    end else if (sample_done && acc_last) begin
      result_reg <= acc_new;
      result_unread_reg <= 1'b1;
    end else if (rd_go && rd_idx == `IDX_RESULT) begin
      result_unread_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Interrupt flags: a set in the same cycle as a clear wins.
  // With the sample source the window is judged on each sample; otherwise on each result.
  assign win_value = window_ctrl_reg[`WINDOW_SOURCE_SELECT_BIT] ? sample_data : acc_new[15:0];

  always_comb begin
    flag_set = '0;
    flag_set.trigger_overrun = start_trigger && state_reg == SEQ_CONVERT;
    flag_set.sample_overwrite = sample_done && sample_unread_reg;
    flag_set.result_overwrite = sample_done && acc_last && result_unread_reg;
    flag_set.window_match = sample_done && (acc_last || window_ctrl_reg[`WINDOW_SOURCE_SELECT_BIT]) &&
                            win_hit(window_ctrl_reg[`WINDOW_COMPARE_MODE_MSB:`WINDOW_COMPARE_MODE_LSB], win_value,
                                    win_low_reg, win_high_reg);
    flag_set.sample_ready = sample_done;
    flag_set.result_ready = sample_done && acc_last;
    flag_clr = '0;
    if (wr_go && wstrb_reg[0] && wr_idx == `IDX_IRQ_FLAGS) begin
      flag_clr = irq_bits_t'(wdata_reg[5:0]);
    end
    if (rd_go && rd_idx == `IDX_SAMPLE) begin
      flag_clr.sample_ready = 1'b1;
    end
    if (rd_go && rd_idx == `IDX_RESULT) begin
      flag_clr.result_ready = 1'b1;
    end
    irq_flags_next = (irq_flags_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flags_reg <= '0;
    end else begin
      irq_flags_reg <= irq_flags_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_flags_next & irq_enable_reg);
    end
  end

  // ==========================================================================
  // Read channel.
  always_comb begin
    case (rd_idx)
      `IDX_TIMEBASE_REF: rd_value = {24'h0, timebase_ref_reg};
      `IDX_WINDOW_CTRL: rd_value = {24'h0, window_ctrl_reg};
      `IDX_IRQ_ENABLE: rd_value = {26'h0, irq_enable_reg};
      `IDX_IRQ_FLAGS: rd_value = {26'h0, irq_flags_reg};
      `IDX_STATUS: rd_value = {31'h0, converter_busy};
      `IDX_ACC_COUNT: rd_value = {28'h0, acc_count_reg};
      `IDX_RESULT: rd_value = result_reg;
      `IDX_SAMPLE: rd_value = {16'h0, sample_reg};
      `IDX_WIN_LOW: rd_value = {16'h0, win_low_reg};
      `IDX_WIN_HIGH: rd_value = {16'h0, win_high_reg};
      default: rd_value = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : adc_window_irq_status

// ---- tb/adc_window_irq_status_props.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the converter control block.
module adc_window_irq_status_props (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter link.
  input wire logic start_trigger,
  input wire logic sample_valid,
  input wire logic conv_start,
  input wire logic converter_busy,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A conversion is open from its start pulse until its sample arrives.
  logic conv_open_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) conv_open_reg <= 1'b0;
    else if (conv_start) conv_open_reg <= 1'b1;
    else if (sample_valid) conv_open_reg <= 1'b0;
  end

  conv_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start lasted more than one cycle");
  busy_on_trigger_a: assert property (start_trigger && !converter_busy |=> converter_busy)
    else $error("busy did not rise after a start trigger");
  busy_in_conv_a: assert property (conv_open_reg |-> converter_busy)
    else $error("busy low while a conversion was open");
  idle_quiet_a: assert property (!converter_busy && !start_trigger |=> !conv_start)
    else $error("conversion started without a trigger");
  write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response did not close");
  write_hold_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while a response was pending");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response did not close");
  read_hold_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while a response was pending");

  cover property (conv_start);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(irq));
endmodule : adc_window_irq_status_props

bind adc_window_irq_status adc_window_irq_status_props u_props (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .start_trigger, .sample_valid, .conv_start, .converter_busy, .irq);

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "adc_window_irq_status_defines.svh"
module tb_top
  import adc_window_irq_status_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic start_trigger, sample_valid, conv_start, converter_busy, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, sum;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] sample_data, lo, hi, last;
  logic [2:0] reference_select, mode;
  logic src, wm;
  logic [31:0] seed = 32'h0ecd;
  int bad_count = 0;
  int n_compared = 0;
  irq_bits_t ef;

  adc_window_irq_status dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .start_trigger, .sample_valid, .sample_data, .conv_start,
    .reference_select, .converter_busy, .irq);

  initial aclk = 1'b0;
  always #25 aclk = ~aclk;

  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic win(input logic [2:0] m, input logic [15:0] x);
    case (m)
      3'h1: return x < lo;
      3'h2: return x > hi;
      3'h3: return x > lo && x < hi;
      3'h4: return x < lo || x > hi;
      default: return 1'b0;
    endcase
  endfunction : win

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic b_ok;
    int n;
    b_ok = 1'b0;
    n = 0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_ok && n < 200) begin
      @(posedge aclk);
      n++;
      b_ok = s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    check("bresp", er, b_ok ? s_axi_bresp : 2'h1);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    check($sformatf("rdata %h", idx), ed, s_axi_rdata);
    check("rresp", er, s_axi_rvalid ? s_axi_rresp : 2'h1);
  endtask : rd

  // One trigger (a second one in the first conversion when extra is set), then one sample per start pulse; expectations built alongside.
  task automatic conv(input int ns, input bit extra);
    int n;
    logic [15:0] v;
    start_trigger <= 1'b1;
    @(posedge aclk);
    start_trigger <= 1'b0;
    sum = 32'h0;
    wm = 1'b0;
    for (int i = 0; i < ns; i++) begin
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (!conv_start && n < 3000);
      check("conv_start", 1, conv_start);
      if (i == 0 && extra) begin
        start_trigger <= 1'b1;
        @(posedge aclk);
        start_trigger <= 1'b0;
      end
      if (i == 0) rd(`IDX_STATUS, 1, 0);
      v = 16'h07f8 + 16'(rnd() % 16);
      repeat (rnd() % 4) @(posedge aclk);
      sample_data <= v;
      sample_valid <= 1'b1;
      @(posedge aclk);
      sample_valid <= 1'b0;
      sample_data <= ~v;
      sum += 32'(v);
      last = v;
      if (src) wm |= win(mode, v);
    end
    if (!src) wm = win(mode, sum[15:0]);
    repeat (3) @(posedge aclk);
    rd(`IDX_STATUS, 0, 0);
  endtask : conv

  // ==========================================================================
  // Main sequence.
  initial begin
    logic [2:0] codes [6];
    int n, k;
    codes = '{3'h4, 3'h0, 3'h5, 3'h2, 3'h6, 3'h7};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {start_trigger, sample_valid, sample_data, s_axi_wdata} = 50'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 20'h0000f;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`IDX_WINDOW_CTRL, 0, 0);
    rd(`IDX_IRQ_FLAGS, 0, 0);
    rd(`IDX_STATUS, 0, 0);
    rd(6'h3f, 0, 2);
    wr(6'h3f, 32'hff, 2);
    wr(`IDX_IRQ_ENABLE, 32'hff, 0);
    rd(`IDX_IRQ_ENABLE, 32'h3f, 0);
    // Settling: 1 us is four clocks with a timebase of three.
    foreach (codes[i]) begin
      wr(`IDX_TIMEBASE_REF, {24'h0, 5'h03, codes[i]}, 0);
      check("reference_select", codes[i], reference_select);
      // Busy rises one edge after the write lands, so let that edge pass first.
      @(posedge aclk);
      n = 0;
      while (converter_busy && n < 3000) begin
        @(posedge aclk);
        n++;
      end
      check("settle", 1, codes[i][2] ? (n >= 230 && n <= 250) : (n < 20));
      rd(`IDX_TIMEBASE_REF, {24'h0, 5'h03, codes[i]}, 0);
    end
    lo = 16'h07fd;
    for (int t = 0; t < 10; t++) begin
      mode = 3'(t % 5);
      src = 1'(t / 5);
      hi = lo + 16'(2 + t % 5);
      k = src ? int'(rnd() % 3) : 0;
      wr(`IDX_WIN_LOW, 32'(lo), 0);
      wr(`IDX_WIN_HIGH, 32'(hi), 0);
      wr(`IDX_WINDOW_CTRL, {28'h0, src, mode}, 0);
      wr(`IDX_ACC_COUNT, 32'(k), 0);
      conv(1 << k, t == 7);
      ef = {t == 7, k > 0, 1'b0, wm, 2'b11};
      check("irq", 1, irq);
      rd(`IDX_IRQ_FLAGS, 32'(ef), 0);
      rd(`IDX_RESULT, sum, 0);
      rd(`IDX_SAMPLE, 32'(last), 0);
      rd(`IDX_IRQ_FLAGS, 32'(ef & 6'h3c), 0);
      wr(`IDX_IRQ_FLAGS, 32'h04, 0);
      rd(`IDX_IRQ_FLAGS, 32'(ef & 6'h38), 0);
      wr(`IDX_IRQ_FLAGS, 32'h3f, 0);
      check("irq", 0, irq);
    end
    // Two unread results in a row, with the interrupt masked.
    wr(`IDX_WINDOW_CTRL, 0, 0);
    wr(`IDX_ACC_COUNT, 0, 0);
    wr(`IDX_IRQ_ENABLE, 32'h20, 0);
    conv(1, 1'b0);
    conv(1, 1'b0);
    check("irq", 0, irq);
    rd(`IDX_IRQ_FLAGS, 32'h1b, 0);
    wr(`IDX_IRQ_ENABLE, 32'h08, 0);
    // The request follows a new enable one edge after the write lands.
    @(posedge aclk);
    check("irq", 1, irq);
    conclude();
  end

  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    conclude();
  end
endmodule : tb_top
